/* verilog/dpm_top.sv */
// Drive protection monitor: fan wear, undervoltage trip, output inhibit, trip reset, health word.
// Assumes a Wishbone classic master on clk_i; pins are asynchronous and are synchronised here.
// Notes on behaviour
// - Fan running time is accumulated against rated life and a warning is raised at the threshold.
// - Fan usage reads as a 16-bit count in steps of 0.1 percent.
// - Writing one to the clear bit zeroes fan usage, writing zero leaves it.
// - The threshold accepts 0.0 to 100.0 percent and the warning follows the comparison.
// - Low DC-link voltage stops the output and enters the trip state.
// - The undervoltage output turns on only after the programmed delay of 0 to 60 s.
// - The inhibit input while running blocks the output and shows the inhibit indication.
// - Frequency and current at inhibit are held and readable while inhibit lasts.
// - Operation resumes only after inhibit is released and a new run command arrives.
// - A latched trip clears on a reset-function input or the keypad reset key.
// - The health word reads zero, or bit pattern 01 when fan replacement is due.
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "dpm_cfg.svh"
module dpm_top #(
    parameter logic [44:0] FAN_TICK_CYC = 45'(`DPM_FAN_TICK_CYC),
    parameter logic [23:0] UV_STEP_CYC  = 24'(`DPM_UV_STEP_CYC)
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire dpm_pkg::dpm_wb_req_type wb_req_i,
    output logic                         wb_ack_o,
    output logic [31:0]                  wb_dat_o,
    input  wire dpm_pkg::dpm_pin_type    pins_i,
    input  wire logic [15:0]             freq_i,
    input  wire logic [15:0]             curr_i,
    output logic                         gate_en_o,
    output logic                         inhibit_o,
    output logic                         uv_trip_o,
    output logic                         fan_warn_o,
    output logic                         xo_o,
    output logic                         irq_o
);
    import dpm_pkg::*;

    dpm_state_type state_r;
    dpm_state_type state_nxt;
    logic [4:0]    sync1_r;
    logic [4:0]    sync2_r;
    logic [4:0]    prev_r;
    logic          ack_r;
    logic [31:0]   rdat_r;
    logic [15:0]   thresh_r;
    logic [15:0]   wear_r;
    logic [44:0]   fan_cnt_r;
    logic [9:0]    uvdly_r;
    logic [23:0]   uv_cnt_r;
    logic [9:0]    uv_steps_r;
    logic          uv_sig_r;
    logic          fan_warn_r;
    logic          xo_r;
    logic [2:0]    istat_r;
    logic [2:0]    imask_r;
    logic          irq_r;
    logic [15:0]   hfreq_r;
    logic [15:0]   hcurr_r;
    logic [15:0]   infunc_r;
    logic [7:0]    outfunc_r;
    logic          wr_ev;
    logic          rd_ev;
    logic [5:0]    widx;
    logic [31:0]   wmask;
    logic [31:0]   wdat;
    logic          run_pulse;
    logic          stop_pulse;
    logic          clr_pulse;
    logic          fan_run_s;
    logic          dc_low_s;
    logic          inh_s;
    logic          rst_in_s;
    logic          rst_in_p;
    logic          clr_req;
    logic [2:0]    ev;
    logic [1:0]    health;

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            prev_r  <= 5'h00;
        end else begin
            sync1_r <= pins_i;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Decoded pin levels and input function mapping
    assign fan_run_s = sync2_r[4];
    assign dc_low_s  = sync2_r[3];
    assign inh_s     = (sync2_r[1] && infunc_r[7:0] == `DPM_FN_INHIBIT)
                     || (sync2_r[2] && infunc_r[15:8] == `DPM_FN_INHIBIT);
    assign rst_in_s  = (sync2_r[1] && infunc_r[7:0] == `DPM_FN_RESET)
                     || (sync2_r[2] && infunc_r[15:8] == `DPM_FN_RESET);
    assign rst_in_p  = (prev_r[1] && infunc_r[7:0] == `DPM_FN_RESET)
                     || (prev_r[2] && infunc_r[15:8] == `DPM_FN_RESET);
    assign clr_req   = (rst_in_s && !rst_in_p) || (sync2_r[0] && !prev_r[0]);

    // Bus decode; a request is served once, in the cycle before ack
    assign wr_ev = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && !ack_r;
    assign rd_ev = wb_req_i.cyc && wb_req_i.stb && !wb_req_i.we && !ack_r;
    assign widx  = wb_req_i.adr[7:2];
    assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}}, {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    assign wdat  = wb_req_i.dat & wmask;
    assign run_pulse  = wr_ev && widx == `DPM_ADR_CTRL && wdat[`DPM_CTRL_RUN];
    assign stop_pulse = wr_ev && widx == `DPM_ADR_CTRL && wdat[`DPM_CTRL_STOP];
    assign clr_pulse  = wr_ev && widx == `DPM_ADR_CTRL && wdat[`DPM_CTRL_CLR];
    assign health     = {1'b0, fan_warn_r};

    // Drive state selection
    always_comb begin
        state_nxt = state_r;
        if (dc_low_s && state_r != DPM_TRIP) begin
            state_nxt = DPM_TRIP;
        end else begin
            unique case (state_r)
                DPM_IDLE: if (run_pulse && !inh_s) state_nxt = DPM_RUN;
                DPM_RUN: begin
                    if (inh_s) state_nxt = DPM_INH;
                    else if (stop_pulse) state_nxt = DPM_IDLE;
                end
                DPM_INH: begin
                    if (!inh_s && run_pulse) state_nxt = DPM_RUN;
                    else if (stop_pulse) state_nxt = DPM_IDLE;
                end
                DPM_TRIP: if (clr_req && !dc_low_s) state_nxt = DPM_IDLE;
                default: state_nxt = DPM_IDLE;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) state_r <= DPM_IDLE;
        else state_r <= state_nxt;
    end

    // Capture of frequency and current when inhibit starts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hfreq_r <= 16'h0000;
            hcurr_r <= 16'h0000;
        end else if (state_r != DPM_INH && state_nxt == DPM_INH) begin
            hfreq_r <= freq_i;
            hcurr_r <= curr_i;
        end
    end

    // Fan running time and wear in 0.1 percent steps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fan_cnt_r <= 45'h0;
            wear_r    <= 16'h0000;
        end else if (clr_pulse) begin
            fan_cnt_r <= 45'h0;
            wear_r    <= 16'h0000;
        end else if (fan_run_s) begin
            if (fan_cnt_r >= FAN_TICK_CYC - 45'h1) begin
                fan_cnt_r <= 45'h0;
                if (wear_r != `DPM_WEAR_MAX) wear_r <= wear_r + 16'h0001;
            end else begin
                fan_cnt_r <= fan_cnt_r + 45'h1;
            end
        end
    end

    // Replacement warning from wear against threshold
    always_ff @(posedge clk_i) begin
        if (rst_i) fan_warn_r <= 1'b0;
        else fan_warn_r <= wear_r >= thresh_r;
    end

    // Undervoltage delay in 0.1 s steps while tripped
    always_ff @(posedge clk_i) begin
        if (rst_i || state_r != DPM_TRIP) begin
            uv_cnt_r   <= 24'h0;
            uv_steps_r <= 10'h000;
            uv_sig_r   <= 1'b0;
        end else if (uv_steps_r >= uvdly_r) begin
            uv_sig_r <= 1'b1;
        end else if (uv_cnt_r >= UV_STEP_CYC - 24'h1) begin
            uv_cnt_r   <= 24'h0;
            uv_steps_r <= uv_steps_r + 10'h001;
        end else begin
            uv_cnt_r <= uv_cnt_r + 24'h1;
        end
    end

    // Transistor output function select
    always_ff @(posedge clk_i) begin
        if (rst_i) xo_r <= 1'b0;
        else if (outfunc_r == `DPM_FN_FANX) xo_r <= fan_warn_r;
        else if (outfunc_r == `DPM_FN_UV) xo_r <= uv_sig_r;
        else xo_r <= 1'b0;
    end

    // Software settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thresh_r  <= `DPM_THRESH_RST;
            uvdly_r   <= `DPM_UVDLY_RST;
            imask_r   <= 3'h0;
            infunc_r  <= `DPM_INFUNC_RST;
            outfunc_r <= `DPM_OUTFUNC_RST;
        end else if (wr_ev) begin
            unique case (widx)
                `DPM_ADR_THRESH: begin
                    if (((thresh_r & ~wmask[15:0]) | wdat[15:0]) > `DPM_THRESH_MAX) thresh_r <= `DPM_THRESH_MAX;
                    else thresh_r <= (thresh_r & ~wmask[15:0]) | wdat[15:0];
                end
                `DPM_ADR_UVDLY: begin
                    if (((uvdly_r & ~wmask[9:0]) | wdat[9:0]) > `DPM_UVDLY_MAX) uvdly_r <= `DPM_UVDLY_MAX;
                    else uvdly_r <= (uvdly_r & ~wmask[9:0]) | wdat[9:0];
                end
                `DPM_ADR_IMASK:   imask_r   <= (imask_r & ~wmask[2:0]) | wdat[2:0];
                `DPM_ADR_INFUNC:  infunc_r  <= (infunc_r & ~wmask[15:0]) | wdat[15:0];
                `DPM_ADR_OUTFUNC: outfunc_r <= (outfunc_r & ~wmask[7:0]) | wdat[7:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a new event wins over a write-one clear
    assign ev[`DPM_INT_FANX] = (wear_r >= thresh_r) && !fan_warn_r;
    assign ev[`DPM_INT_UV]   = state_nxt == DPM_TRIP && state_r != DPM_TRIP;
    assign ev[`DPM_INT_INH]  = state_nxt == DPM_INH && state_r != DPM_INH;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            istat_r <= 3'h0;
            irq_r   <= 1'b0;
        end else begin
            if (wr_ev && widx == `DPM_ADR_ISTAT) istat_r <= (istat_r & ~wdat[2:0]) | ev;
            else istat_r <= istat_r | ev;
            irq_r <= |(istat_r & imask_r);
        end
    end

    // Bus answer and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= wb_req_i.cyc && wb_req_i.stb && !ack_r;
            if (rd_ev) begin
                unique case (widx)
                    `DPM_ADR_THRESH:  rdat_r <= {16'h0000, thresh_r};
                    `DPM_ADR_WEAR:    rdat_r <= {16'h0000, wear_r};
                    `DPM_ADR_UVDLY:   rdat_r <= {22'h0, uvdly_r};
                    `DPM_ADR_STAT:    rdat_r <= {26'h0, uv_sig_r, fan_warn_r, state_r};
                    `DPM_ADR_HEALTH:  rdat_r <= {30'h0, health};
                    `DPM_ADR_ISTAT:   rdat_r <= {29'h0, istat_r};
                    `DPM_ADR_IMASK:   rdat_r <= {29'h0, imask_r};
                    `DPM_ADR_HFREQ:   rdat_r <= {16'h0000, hfreq_r};
                    `DPM_ADR_HCURR:   rdat_r <= {16'h0000, hcurr_r};
                    `DPM_ADR_INFUNC:  rdat_r <= {16'h0000, infunc_r};
                    `DPM_ADR_OUTFUNC: rdat_r <= {24'h0, outfunc_r};
                    default:          rdat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Outputs straight from flip-flops
    assign wb_ack_o   = ack_r;
    assign wb_dat_o   = rdat_r;
    assign gate_en_o  = state_r[1]; // One-hot RUN bit
    assign inhibit_o  = state_r[2]; // One-hot INH bit
    assign uv_trip_o  = state_r[3]; // One-hot TRIP bit
    assign fan_warn_o = fan_warn_r;
    assign xo_o       = xo_r;
    assign irq_o      = irq_r;

    // Checks on the block's own behaviour
    sequence s_trip_entry;
        state_r != DPM_TRIP ##1 state_r == DPM_TRIP;
    endsequence
    property p_fan_warn;
        @(posedge clk_i) disable iff (rst_i) (wear_r >= thresh_r) |=> fan_warn_r;
    endproperty
    a_fan_warn: assert property (p_fan_warn) else $error("fan warning missing");
    property p_thresh;
        @(posedge clk_i) disable iff (rst_i) thresh_r <= `DPM_THRESH_MAX;
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold out of range");
    property p_clear;
        @(posedge clk_i) disable iff (rst_i) clr_pulse |=> wear_r == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("wear not cleared");
    property p_sat;
        @(posedge clk_i) disable iff (rst_i) (wear_r == `DPM_WEAR_MAX && !clr_pulse) |=> wear_r == `DPM_WEAR_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("wear wrapped");
    property p_uv_trip;
        @(posedge clk_i) disable iff (rst_i) dc_low_s |=> state_r == DPM_TRIP && !gate_en_o;
    endproperty
    a_uv_trip: assert property (p_uv_trip) else $error("no trip on low voltage");
    property p_uv_delay;
        @(posedge clk_i) disable iff (rst_i) (s_trip_entry ##0 uvdly_r == 10'h000) |-> !uv_sig_r ##1 uv_sig_r;
    endproperty
    a_uv_delay: assert property (p_uv_delay) else $error("undervoltage signal timing");
    property p_inhibit;
        @(posedge clk_i) disable iff (rst_i) (state_r == DPM_RUN && inh_s && !dc_low_s) |=> inhibit_o && !gate_en_o;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit not taken");
    property p_hold;
        @(posedge clk_i) disable iff (rst_i) (state_r == DPM_INH && $past(state_r) == DPM_INH) |-> $stable(hfreq_r);
    endproperty
    a_hold: assert property (p_hold) else $error("held frequency moved");
    property p_resume;
        @(posedge clk_i) disable iff (rst_i) (state_r == DPM_INH && !run_pulse) |=> state_r != DPM_RUN;
    endproperty
    a_resume: assert property (p_resume) else $error("resumed without run");
    property p_reset;
        @(posedge clk_i) disable iff (rst_i) (state_r == DPM_TRIP && clr_req && !dc_low_s) |=> state_r == DPM_IDLE;
    endproperty
    a_reset: assert property (p_reset) else $error("trip not cleared");
endmodule // dpm_top

/* verilog/dpm_cfg.svh */
// Offsets, field positions, reset values and timing counts of the drive protection monitor.
// Assumes a 100 MHz system clock and a Wishbone byte address space of 8 bits.
`ifndef DPM_CFG_SVH
`define DPM_CFG_SVH
`define DPM_ADR_CTRL     6'h00
`define DPM_ADR_THRESH   6'h01
`define DPM_ADR_WEAR     6'h02
`define DPM_ADR_UVDLY    6'h03
`define DPM_ADR_STAT     6'h04
`define DPM_ADR_HEALTH   6'h05
`define DPM_ADR_ISTAT    6'h06
`define DPM_ADR_IMASK    6'h07
`define DPM_ADR_HFREQ    6'h08
`define DPM_ADR_HCURR    6'h09
`define DPM_ADR_INFUNC   6'h0A
`define DPM_ADR_OUTFUNC  6'h0B
`define DPM_CTRL_CLR     0
`define DPM_CTRL_RUN     1
`define DPM_CTRL_STOP    2
`define DPM_INT_FANX     0
`define DPM_INT_UV       1
`define DPM_INT_INH      2
`define DPM_THRESH_RST   16'h0384
`define DPM_THRESH_MAX   16'h03E8
`define DPM_WEAR_MAX     16'hFFFF
`define DPM_UVDLY_RST    10'h000
`define DPM_UVDLY_MAX    10'h258
`define DPM_FN_RESET     8'h03
`define DPM_FN_INHIBIT   8'h05
`define DPM_FN_UV        8'h0B
`define DPM_FN_FANX      8'h25
`define DPM_INFUNC_RST   16'h0305
`define DPM_OUTFUNC_RST  8'h25
`define DPM_CLK_KHZ      100000
`define DPM_FAN_LIFE_H   50000
`define DPM_FAN_TICK_CYC (64'd50000 * 64'd3600 * 64'd1000 * 64'd100000 / 64'd1000)
`define DPM_UV_STEP_MS   100
`define DPM_UV_STEP_CYC  (`DPM_UV_STEP_MS * `DPM_CLK_KHZ)
`endif

/* verilog/dpm_pkg.sv */
// Types of the drive protection monitor.
// Assumes dpm_cfg.svh is compiled alongside.
package dpm_pkg;
    // Drive states, one-hot
    typedef enum logic [3:0] {
        DPM_IDLE = 4'b0001,
        DPM_RUN  = 4'b0010,
        DPM_INH  = 4'b0100,
        DPM_TRIP = 4'b1000
    } dpm_state_type;
    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } dpm_wb_req_type;
    // Drive pins sampled by the monitor
    typedef struct packed {
        logic       fan_run;
        logic       dc_low;
        logic [1:0] mf_in;
        logic       key_reset;
    } dpm_pin_type;
endpackage

/* sim/tb_drive_protection_monitor.sv */
// Self-checking bench of the drive protection monitor: bus, fan wear, inhibit, undervoltage trip.
// Assumes dpm_pkg and dpm_top are compiled first; short tick parameters keep the run brief.
`timescale 1ns/10ps
module tb_drive_protection_monitor;
    import dpm_pkg::*;
    logic           clk_i;
    logic           rst_i;
    dpm_wb_req_type wb_req;
    logic           wb_ack_o;
    logic [31:0]    wb_dat_o;
    dpm_pin_type    pins;
    logic [15:0]    freq_i;
    logic [15:0]    curr_i;
    logic           gate_en_o;
    logic           inhibit_o;
    logic           uv_trip_o;
    logic           fan_warn_o;
    logic           xo_o;
    logic           irq_o;
    int             num_errors;
    int             checks;
    int             n;
    logic [31:0]    w1;

    // Short tick counts so that wear and delay steps take a few cycles
    dpm_top #(.FAN_TICK_CYC(45'h4), .UV_STEP_CYC(24'h4)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .pins_i(pins), .freq_i(freq_i), .curr_i(curr_i), .gate_en_o(gate_en_o), .inhibit_o(inhibit_o),
        .uv_trip_o(uv_trip_o), .fan_warn_o(fan_warn_o), .xo_o(xo_o), .irq_o(irq_o)
    );

    // Clock of 10 ns
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // Counts a comparison and reports a mismatch
    task check_val(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints counts and verdict, then ends the run
    task print_verdict;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One classic Wishbone cycle, held until ack is sampled high at a rising edge
    task wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_req <= '0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, q);
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, a, 32'h0, q);
        check_val(q, exp);
    endtask

    task tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask

    // Watchdog against a hung handshake or wait
    initial begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        print_verdict;
    end

    // Main sequence
    initial begin
        wb_req = '0;
        pins = '0;
        freq_i = 16'h1234;
        curr_i = 16'h0567;
        rst_i = 1'b1;
        num_errors = 0;
        checks = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values and an unmapped place
        rd_chk(8'h04, 32'h0000_0384);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h0C, 32'h0);
        rd_chk(8'h10, 32'h1);
        rd_chk(8'h14, 32'h0);
        rd_chk(8'h28, 32'h0000_0305);
        rd_chk(8'h2C, 32'h0000_0025);
        rd_chk(8'h3C, 32'h0);
        check_val(fan_warn_o, 1'b0);
        // Threshold clamps at 100.0 percent
        wr(8'h04, 32'h0000_07D0);
        rd_chk(8'h04, 32'h0000_03E8);
        wr(8'h04, 32'h3);
        wr(8'h1C, 32'h1);
        // Fan runs until the warning rises
        @(posedge clk_i);
        pins.fan_run <= 1'b1;
        for (n = 0; n < 300 && fan_warn_o !== 1'b1; n++) @(negedge clk_i);
        check_val(fan_warn_o, 1'b1);
        check_val(n >= 11, 1'b1);
        @(negedge clk_i);
        check_val(xo_o, 1'b1);
        @(posedge clk_i);
        pins.fan_run <= 1'b0;
        tick(8);
        wb_cycle(1'b0, 8'h08, 32'h0, w1);
        check_val(w1 >= 32'h3 && w1 <= 32'h5, 1'b1);
        tick(20);
        rd_chk(8'h08, w1);
        rd_chk(8'h14, 32'h1);
        // Interrupt raised, cleared by writing one
        rd_chk(8'h18, 32'h1);
        check_val(irq_o, 1'b1);
        wr(8'h18, 32'h1);
        tick(2);
        check_val(irq_o, 1'b0);
        // Clear setting: zero keeps, one clears
        wr(8'h00, 32'h0);
        rd_chk(8'h08, w1);
        wr(8'h00, 32'h1);
        rd_chk(8'h08, 32'h0);
        tick(3);
        check_val(fan_warn_o, 1'b0);
        rd_chk(8'h14, 32'h0);
        wr(8'h04, 32'h0);
        tick(3);
        check_val(fan_warn_o, 1'b1);
        check_val(irq_o, 1'b1);
        wr(8'h1C, 32'h0);
        tick(2);
        check_val(irq_o, 1'b0);
        wr(8'h04, 32'h0000_03E8);
        // Run, then inhibit
        wr(8'h00, 32'h2);
        tick(2);
        check_val(gate_en_o, 1'b1);
        @(posedge clk_i);
        pins.mf_in <= 2'b01;
        tick(6);
        check_val(inhibit_o, 1'b1);
        check_val(gate_en_o, 1'b0);
        @(posedge clk_i);
        freq_i <= 16'hBEEF;
        curr_i <= 16'h0AAA;
        rd_chk(8'h20, 32'h0000_1234);
        rd_chk(8'h24, 32'h0000_0567);
        wr(8'h00, 32'h2);
        tick(2);
        check_val(inhibit_o, 1'b1);
        @(posedge clk_i);
        pins.mf_in <= 2'b00;
        tick(6);
        check_val(gate_en_o, 1'b0);
        wr(8'h00, 32'h2);
        tick(2);
        check_val(gate_en_o, 1'b1);
        check_val(inhibit_o, 1'b0);
        // Stop command returns the drive to idle
        wr(8'h00, 32'h4);
        tick(2);
        check_val(gate_en_o, 1'b0);
        rd_chk(8'h10, 32'h1);
        // Undervoltage trip with a delayed output
        wr(8'h0C, 32'h2);
        wr(8'h2C, 32'h0000_000B);
        @(posedge clk_i);
        pins.dc_low <= 1'b1;
        for (n = 0; n < 50 && uv_trip_o !== 1'b1; n++) @(negedge clk_i);
        check_val(uv_trip_o, 1'b1);
        check_val(gate_en_o, 1'b0);
        repeat (3) @(negedge clk_i);
        check_val(xo_o, 1'b0);
        for (n = 0; n < 60 && xo_o !== 1'b1; n++) @(negedge clk_i);
        check_val(xo_o, 1'b1);
        check_val(n >= 4, 1'b1);
        // Latched trip cleared by reset input, then by the key
        @(posedge clk_i);
        pins.dc_low <= 1'b0;
        tick(8);
        check_val(uv_trip_o, 1'b1);
        @(posedge clk_i);
        pins.mf_in <= 2'b10;
        tick(6);
        check_val(uv_trip_o, 1'b0);
        check_val(xo_o, 1'b0);
        // Second trip with zero delay: output follows within a few cycles
        wr(8'h0C, 32'h0);
        @(posedge clk_i);
        pins.mf_in <= 2'b00;
        pins.dc_low <= 1'b1;
        tick(6);
        check_val(uv_trip_o, 1'b1);
        check_val(xo_o, 1'b1);
        @(posedge clk_i);
        pins.dc_low <= 1'b0;
        tick(4);
        @(posedge clk_i);
        pins.key_reset <= 1'b1;
        tick(6);
        check_val(uv_trip_o, 1'b0);
        rd_chk(8'h10, 32'h1);
        rd_chk(8'h18, 32'h7);
        print_verdict;
    end
endmodule // tb_drive_protection_monitor
